//--- sweep_trigger_pkg.sv
// Purpose: constants, types and helpers of the sweep and trigger controller
// Assumes: 50 MHz mclk, all times held in microseconds, span held in MHz
// Notes:
// What this block does
// - coupled sweep time: 20 ms per 600 MHz
// - zero span sweep time from 200 us to 1000 s
// - zero span axis runs 0 to sweep time
// - continuous mode restarts and refreshes after each sweep
// - single mode runs average count sweeps, halts
// - free run starts next sweep at once
// - video trigger on rising crossing, zero span only
// - video level is percent of reference level
// - external trigger on chosen rising or falling edge
// - trigger delay from 0 to 100 s
// - delay step grows by decade, 10 us up to 1 s
// - gate: delay, measure gate length, pause, resume
// - gating only with the external source
// - no gating with forced FFT sweep
// - gating works with and without span
// - gate editing forces zero span, then restores span
package sweep_trigger_pkg;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int US_NS = 1000;
    localparam int TICK_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [31:0] COUPLE_TIME_MS = 32'h14;
    localparam logic [31:0] COUPLE_TIME_US = COUPLE_TIME_MS * 32'h3e8;
    localparam logic [31:0] COUPLE_SPAN_MHZ = 32'h258;
    localparam logic [31:0] ZS_MIN_TIME_US = 32'hc8;
    localparam logic [31:0] MAX_SWEEP_S = 32'h3e8;
    localparam logic [31:0] MAX_SWEEP_US = MAX_SWEEP_S * 32'hf4240;
    localparam logic [31:0] MAX_DELAY_S = 32'h64;
    localparam logic [31:0] MAX_DELAY_US = MAX_DELAY_S * 32'hf4240;
    localparam logic [7:0] FULL_SCALE_PCT = 8'h64;
    // ---------------------------------------------------------------
    // register byte addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_SPAN = 8'h08;
    localparam logic [7:0] ADDR_SWTIME = 8'h0c;
    localparam logic [7:0] ADDR_TRIGDLY = 8'h10;
    localparam logic [7:0] ADDR_VIDPCT = 8'h14;
    localparam logic [7:0] ADDR_REFLVL = 8'h18;
    localparam logic [7:0] ADDR_GATEDLY = 8'h1c;
    localparam logic [7:0] ADDR_GATELEN = 8'h20;
    localparam logic [7:0] ADDR_AVG = 8'h24;
    localparam logic [7:0] ADDR_STATUS = 8'h28;
    localparam logic [7:0] ADDR_EFFTIME = 8'h2c;
    localparam logic [7:0] ADDR_TIMEPOS = 8'h30;
    // ---------------------------------------------------------------
    // control fields and reset values
    // ---------------------------------------------------------------
    localparam int CTRL_SINGLE = 0;
    localparam int CTRL_MANUAL = 1;
    localparam int CTRL_SRC_LSB = 2;
    localparam int CTRL_FALL = 4;
    localparam int CTRL_GATE = 5;
    localparam int CTRL_FFT = 6;
    localparam int CTRL_GEDIT = 7;
    localparam int CMD_START = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] AVG_RESET = 16'h0001;
    localparam logic [7:0] VIDPCT_RESET = 8'h32;
    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {SRC_FREE = 2'b00, SRC_VIDEO = 2'b01, SRC_EXT = 2'b10} trigSrc_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ARM = 3'b001,
        ST_DELAY = 3'b010,
        ST_SWEEP = 3'b011,
        ST_PAUSE = 3'b100
    } state_t;
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // step size of a delay value by its decade
    function automatic logic [31:0] delayStep(input logic [31:0] v);
        if (v < 32'h3e8) return 32'ha;
        else if (v < 32'h2710) return 32'h64;
        else if (v < 32'h186a0) return 32'h3e8;
        else if (v < 32'hf4240) return 32'h2710;
        else if (v < 32'h989680) return 32'h186a0;
        else return 32'hf4240;
    endfunction
    // clamp to range, then round down onto the step grid
    function automatic logic [31:0] quantDelay(input logic [31:0] v);
        logic [31:0] c;
        c = (v > MAX_DELAY_US) ? MAX_DELAY_US : v;
        return c - (c % delayStep(c));
    endfunction
    // shortest coupled time: whole 20 ms per started 600 MHz
    function automatic logic [31:0] coupledTime(input logic [15:0] spanMhz);
        logic [31:0] sp;
        sp = {16'h0000, spanMhz};
        return ((sp + COUPLE_SPAN_MHZ - 32'h1) / COUPLE_SPAN_MHZ) * COUPLE_TIME_US;
    endfunction
endpackage

//--- sweep_trigger_control.sv
// Purpose: sweep sequencing, trigger, delay and gate control behind APB
// Assumes: inputs synchronous except extTrig; pready always high
// Notes: all times in microseconds, counted on a 1 us enable pulse
`timescale 1ns/1ps
`default_nettype none
module sweep_trigger_control (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // measurement inputs
    input wire logic extTrig,
    input wire logic [15:0] videoLevel,
    // sweep outputs
    output logic measuring,
    output logic sweepDone,
    output logic trigEvent,
    output logic zeroSpan,
    output logic [31:0] timeAxis
);
    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] ctrl_r; // mode bits
    logic [15:0] span_r; // span in MHz, zero means time domain
    logic [31:0] manTime_r; // manual sweep time
    logic [31:0] trigDelay_r; // quantised trigger delay
    logic [7:0] vidPct_r; // video level in percent
    logic [15:0] refLevel_r; // reference level in video units
    logic [31:0] gateDly_r; // gate delay
    logic [31:0] gateLen_r; // gate length
    logic [15:0] avg_r; // sweeps per single run
    logic [31:0] rdData_r; // read data, caught in setup
    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    wire logic wrEn = psel && penable && pwrite;
    wire logic mapped = (paddr[1:0] == 2'b00) && (paddr <= sweep_trigger_pkg::ADDR_TIMEPOS);
    wire logic startPulse = wrEn && (paddr == sweep_trigger_pkg::ADDR_CMD) && pwdata[sweep_trigger_pkg::CMD_START];
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = rdData_r;
    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    wire logic singleMode = ctrl_r[sweep_trigger_pkg::CTRL_SINGLE];
    wire logic manualTime = ctrl_r[sweep_trigger_pkg::CTRL_MANUAL];
    wire logic [1:0] srcSel = ctrl_r[sweep_trigger_pkg::CTRL_SRC_LSB +: 2];
    wire logic srcVideo = srcSel == sweep_trigger_pkg::SRC_VIDEO;
    wire logic srcExt = srcSel == sweep_trigger_pkg::SRC_EXT;
    wire logic srcFree = !srcVideo && !srcExt; // code 11 behaves as free run
    wire logic extFall = ctrl_r[sweep_trigger_pkg::CTRL_FALL];
    wire logic fftForced = ctrl_r[sweep_trigger_pkg::CTRL_FFT];
    wire logic gateEdit = ctrl_r[sweep_trigger_pkg::CTRL_GEDIT];
    // gating needs the external gate and a swept, non-FFT capture
    wire logic gatedEff = ctrl_r[sweep_trigger_pkg::CTRL_GATE] && srcExt && !fftForced;
    // span register is never touched while editing, so leaving restores it
    wire logic [15:0] spanEff = gateEdit ? 16'h0000 : span_r;
    wire logic zs = spanEff == 16'h0000;
    assign zeroSpan = zs;
    // ---------------------------------------------------------------
    // sweep time selection
    // ---------------------------------------------------------------
    wire logic [31:0] coupledUs = zs ? sweep_trigger_pkg::ZS_MIN_TIME_US
                                     : sweep_trigger_pkg::coupledTime(spanEff);
    // manual time may not undercut the coupled minimum in frequency mode
    wire logic [31:0] lowUs = zs ? sweep_trigger_pkg::ZS_MIN_TIME_US : coupledUs;
    wire logic [31:0] manLoUs = (manTime_r < lowUs) ? lowUs : manTime_r;
    wire logic [31:0] manUs = (manLoUs > sweep_trigger_pkg::MAX_SWEEP_US)
                              ? sweep_trigger_pkg::MAX_SWEEP_US : manLoUs;
    wire logic [31:0] sweepUs = manualTime ? manUs : coupledUs;
    // ---------------------------------------------------------------
    // video threshold
    // ---------------------------------------------------------------
    wire logic [7:0] pctEff = (vidPct_r > sweep_trigger_pkg::FULL_SCALE_PCT)
                              ? sweep_trigger_pkg::FULL_SCALE_PCT : vidPct_r;
    wire logic [23:0] vidProd = refLevel_r * {8'h00, pctEff};
    wire logic [23:0] vidQuot = vidProd / {16'h0000, sweep_trigger_pkg::FULL_SCALE_PCT};
    wire logic [15:0] vidThr = vidQuot[15:0];
    wire logic vidAbove = videoLevel > vidThr;
    logic vidAbovePrev_r; // level one cycle ago, for the crossing
    wire logic vidRise = vidAbove && !vidAbovePrev_r;
    // ---------------------------------------------------------------
    // external input synchroniser and edge detect
    // ---------------------------------------------------------------
    logic extS1_r; // metastable stage, read only by extS2_r
    logic extS2_r; // settled level
    logic extS3_r; // previous settled level
    wire logic extEdge = extFall ? (extS3_r && !extS2_r) : (!extS3_r && extS2_r);
    // sync chain
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            extS1_r <= 1'b0;
            extS2_r <= 1'b0;
            extS3_r <= 1'b0;
            vidAbovePrev_r <= 1'b0;
        end else begin
            extS1_r <= extTrig;
            extS2_r <= extS1_r;
            extS3_r <= extS2_r;
            vidAbovePrev_r <= vidAbove;
        end
    end
    // ---------------------------------------------------------------
    // microsecond enable
    // ---------------------------------------------------------------
    localparam logic [5:0] TICK_LAST = 6'(sweep_trigger_pkg::TICK_CYCLES - 1);
    logic [5:0] tickCnt_r; // cycles within the current microsecond
    wire logic usTick = tickCnt_r == TICK_LAST;
    // free running divider
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) tickCnt_r <= 6'h00;
        else tickCnt_r <= usTick ? 6'h00 : tickCnt_r + 6'h01;
    end
    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    sweep_trigger_pkg::state_t state_r, state_nxt;
    logic [31:0] delay_r, delay_nxt; // remaining delay
    logic [31:0] elapsed_r, elapsed_nxt; // position on the time axis
    logic [31:0] gateCnt_r, gateCnt_nxt; // remaining gate time
    logic [15:0] sweepCnt_r, sweepCnt_nxt; // sweeps done in this run
    logic done_r, done_nxt;
    logic trig_r, trig_nxt;
    wire logic [15:0] avgEff = (avg_r == 16'h0000) ? 16'h0001 : avg_r;
    wire logic lastSweep = (sweepCnt_r + 16'h0001) >= avgEff;
    wire logic sweepEnd = usTick && ((elapsed_r + 32'h1) >= sweepUs);
    // video source can fire only in the time domain; free run never waits
    wire logic trigFire = srcFree || (srcVideo && zs && vidRise) || (srcExt && extEdge);
    // next state
    always_comb begin
        state_nxt = state_r;
        delay_nxt = delay_r;
        elapsed_nxt = elapsed_r;
        gateCnt_nxt = gateCnt_r;
        sweepCnt_nxt = sweepCnt_r;
        done_nxt = 1'b0;
        trig_nxt = 1'b0;
        unique case (state_r)
            sweep_trigger_pkg::ST_IDLE: begin
                // continuous mode needs no start request
                if (startPulse || !singleMode) begin
                    state_nxt = sweep_trigger_pkg::ST_ARM;
                    sweepCnt_nxt = 16'h0000;
                end
            end
            sweep_trigger_pkg::ST_ARM: begin
                if (trigFire) begin
                    elapsed_nxt = 32'h0;
                    trig_nxt = !srcFree;
                    if (srcFree) begin
                        state_nxt = sweep_trigger_pkg::ST_SWEEP;
                    end else begin
                        state_nxt = sweep_trigger_pkg::ST_DELAY;
                        delay_nxt = gatedEff ? gateDly_r : trigDelay_r;
                    end
                end
            end
            sweep_trigger_pkg::ST_DELAY: begin
                if (delay_r == 32'h0) begin
                    state_nxt = sweep_trigger_pkg::ST_SWEEP;
                    gateCnt_nxt = gateLen_r;
                end else if (usTick) begin
                    delay_nxt = delay_r - 32'h1;
                end
            end
            sweep_trigger_pkg::ST_SWEEP: begin
                if (usTick) begin
                    elapsed_nxt = elapsed_r + 32'h1;
                    gateCnt_nxt = (gateCnt_r == 32'h0) ? 32'h0 : gateCnt_r - 32'h1;
                end
                if (sweepEnd) begin
                    done_nxt = 1'b1;
                    sweepCnt_nxt = sweepCnt_r + 16'h0001;
                    if (singleMode && lastSweep) begin
                        state_nxt = sweep_trigger_pkg::ST_IDLE;
                    end else if (srcFree) begin
                        elapsed_nxt = 32'h0;
                    end else begin
                        state_nxt = sweep_trigger_pkg::ST_ARM;
                    end
                end else if (usTick && gatedEff && (gateCnt_r <= 32'h1)) begin
                    state_nxt = sweep_trigger_pkg::ST_PAUSE;
                end
            end
            sweep_trigger_pkg::ST_PAUSE: begin
                // gating switched off: just carry on sweeping
                if (!gatedEff) begin
                    state_nxt = sweep_trigger_pkg::ST_SWEEP;
                end else if (extEdge) begin
                    state_nxt = sweep_trigger_pkg::ST_DELAY;
                    delay_nxt = gateDly_r;
                    trig_nxt = 1'b1;
                end
            end
            default: state_nxt = sweep_trigger_pkg::ST_IDLE;
        endcase
    end
    // sequencer flops
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= sweep_trigger_pkg::ST_IDLE;
            delay_r <= 32'h0;
            elapsed_r <= 32'h0;
            gateCnt_r <= 32'h0;
            sweepCnt_r <= 16'h0000;
            done_r <= 1'b0;
            trig_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            delay_r <= delay_nxt;
            elapsed_r <= elapsed_nxt;
            gateCnt_r <= gateCnt_nxt;
            sweepCnt_r <= sweepCnt_nxt;
            done_r <= done_nxt;
            trig_r <= trig_nxt;
        end
    end
    assign measuring = state_r == sweep_trigger_pkg::ST_SWEEP;
    assign sweepDone = done_r;
    assign trigEvent = trig_r;
    assign timeAxis = elapsed_r;
    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    // writes land in the access phase only
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= sweep_trigger_pkg::CTRL_RESET;
            span_r <= 16'h0000;
            manTime_r <= 32'h0;
            trigDelay_r <= 32'h0;
            vidPct_r <= sweep_trigger_pkg::VIDPCT_RESET;
            refLevel_r <= 16'h0000;
            gateDly_r <= 32'h0;
            gateLen_r <= 32'h0;
            avg_r <= sweep_trigger_pkg::AVG_RESET;
        end else if (wrEn) begin
            unique case (paddr)
                sweep_trigger_pkg::ADDR_CTRL: ctrl_r <= pwdata[7:0];
                sweep_trigger_pkg::ADDR_SPAN: span_r <= pwdata[15:0];
                sweep_trigger_pkg::ADDR_SWTIME: manTime_r <= pwdata;
                sweep_trigger_pkg::ADDR_TRIGDLY: trigDelay_r <= sweep_trigger_pkg::quantDelay(pwdata);
                sweep_trigger_pkg::ADDR_VIDPCT: vidPct_r <= pwdata[7:0];
                sweep_trigger_pkg::ADDR_REFLVL: refLevel_r <= pwdata[15:0];
                sweep_trigger_pkg::ADDR_GATEDLY: gateDly_r <= sweep_trigger_pkg::quantDelay(pwdata);
                sweep_trigger_pkg::ADDR_GATELEN: gateLen_r <= pwdata;
                sweep_trigger_pkg::ADDR_AVG: avg_r <= pwdata[15:0];
                default: ;
            endcase
        end
    end
    // ---------------------------------------------------------------
    // register reads
    // ---------------------------------------------------------------
    logic [31:0] rdMux;
    // status: state, gating allowed, zero span, sweep count
    wire logic [31:0] statusWord = {sweepCnt_r, 11'h000, zs, gatedEff, state_r};
    always_comb begin
        unique case (paddr)
            sweep_trigger_pkg::ADDR_CTRL: rdMux = {24'h000000, ctrl_r};
            sweep_trigger_pkg::ADDR_SPAN: rdMux = {16'h0000, span_r};
            sweep_trigger_pkg::ADDR_SWTIME: rdMux = manTime_r;
            sweep_trigger_pkg::ADDR_TRIGDLY: rdMux = trigDelay_r;
            sweep_trigger_pkg::ADDR_VIDPCT: rdMux = {24'h000000, vidPct_r};
            sweep_trigger_pkg::ADDR_REFLVL: rdMux = {16'h0000, refLevel_r};
            sweep_trigger_pkg::ADDR_GATEDLY: rdMux = gateDly_r;
            sweep_trigger_pkg::ADDR_GATELEN: rdMux = gateLen_r;
            sweep_trigger_pkg::ADDR_AVG: rdMux = {16'h0000, avg_r};
            sweep_trigger_pkg::ADDR_STATUS: rdMux = statusWord;
            sweep_trigger_pkg::ADDR_EFFTIME: rdMux = sweepUs;
            sweep_trigger_pkg::ADDR_TIMEPOS: rdMux = elapsed_r;
            default: rdMux = 32'h0;
        endcase
    end
    // caught in setup so prdata is a flop through the access phase
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) rdData_r <= 32'h0;
        else if (psel && !penable) rdData_r <= rdMux;
    end
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence pauseEdge;
        state_r == sweep_trigger_pkg::ST_PAUSE && gatedEff && extEdge;
    endsequence
    sequence delayEnd;
        state_r == sweep_trigger_pkg::ST_DELAY && delay_r == 32'h0;
    endsequence
    wire logic [63:0] sweepScaled = {32'h0, sweepUs} * {32'h0, sweep_trigger_pkg::COUPLE_SPAN_MHZ};
    wire logic [63:0] spanScaled = {48'h0, spanEff} * {32'h0, sweep_trigger_pkg::COUPLE_TIME_US};
    coupledMin_a: assert property (!manualTime && !zs |-> sweepScaled >= spanScaled)
        else $error("coupled sweep time too short");
    zsRange_a: assert property (zs |-> sweepUs >= 32'hc8 && sweepUs <= 32'h3b9aca00)
        else $error("zero span sweep time out of range");
    axisBound_a: assert property (measuring |-> timeAxis < sweepUs)
        else $error("time axis beyond sweep time");
    contRestart_a: assert property (sweepEnd && measuring && !singleMode |=> sweepDone && state_r != sweep_trigger_pkg::ST_IDLE)
        else $error("continuous sweep did not restart");
    singleHalt_a: assert property (sweepEnd && measuring && singleMode && lastSweep |=> state_r == sweep_trigger_pkg::ST_IDLE [*2])
        else $error("single run did not halt");
    freeRun_a: assert property (sweepEnd && measuring && srcFree && !(singleMode && lastSweep) |=> measuring && timeAxis == 32'h0)
        else $error("free run did not restart at once");
    videoSpan_a: assert property (state_r == sweep_trigger_pkg::ST_ARM && srcVideo && !zs |=> state_r != sweep_trigger_pkg::ST_DELAY)
        else $error("video trigger fired with span");
    fullScale_a: assert property (pctEff == sweep_trigger_pkg::FULL_SCALE_PCT |-> vidThr == refLevel_r)
        else $error("full scale level differs from reference");
    delayGrid_a: assert property (trigDelay_r <= 32'h5f5e100 && trigDelay_r % sweep_trigger_pkg::delayStep(trigDelay_r) == 32'h0)
        else $error("trigger delay off grid or range");
    gateResume_a: assert property (pauseEdge |=> state_r == sweep_trigger_pkg::ST_DELAY ##0 delay_r == $past(gateDly_r))
        else $error("gate did not resume through delay");
    delayStart_a: assert property (delayEnd |=> measuring)
        else $error("sweep did not start after delay");
    gateRefuse_a: assert property (!srcExt || fftForced |-> !gatedEff)
        else $error("gating allowed without external source");
    editSpan_a: assert property (gateEdit |-> zs ##1 (gateEdit || spanEff == span_r))
        else $error("span not forced or restored");
    edgePulse_a: assert property (extEdge |=> !extEdge)
        else $error("edge event longer than one cycle");
endmodule
`default_nettype wire

//--- ext_trig_source.sv
// Purpose: external trigger or gate source on the trigger pin
// Assumes: lvl is moved by the bench just after an edge
// Notes: pin moves one edge after the request, like a registered source
`timescale 1ns/1ps
`default_nettype none
module ext_trig_source (
    // clock and request
    input wire logic mclk,
    input wire logic lvl,
    // trigger pin
    output logic extTrig
);
    // idle low before the first edge
    initial extTrig = 1'b0;
    // pin follows the request just after the edge, never on the sampling instant
    always @(posedge mclk) begin
        extTrig <= lvl;
    end
endmodule
`default_nettype wire

//--- testbench.sv
// Purpose: register, sweep and trigger checks of sweep_trigger_control
// Assumes: 50 MHz mclk, apb slave answers when pready is high
// Notes: gating gets one short gated run; sweeps are 200 us to keep the run short
`timescale 1ns/1ps
`default_nettype none
`define CHK(g,e) begin nChecks++; if ((g) !== (e)) begin errCount++; $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
`define WAIT(s,n) for (k = 0; k < n && s !== 1'b1; k++) @(posedge mclk);
module testbench;
    logic mclk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pinLvl = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, timeAxis, rd;
    logic [15:0] videoLevel = 16'h0;
    logic pready, pslverr, extTrig, measuring, sweepDone, trigEvent, zeroSpan, se;
    int errCount = 0, nChecks = 0, cyc = 0, k;
    always #10 mclk = ~mclk;
    ext_trig_source src_u (.mclk(mclk), .lvl(pinLvl), .extTrig(extTrig));
    sweep_trigger_control dut_u (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .extTrig(extTrig),
        .videoLevel(videoLevel), .measuring(measuring), .sweepDone(sweepDone), .trigEvent(trigEvent),
        .zeroSpan(zeroSpan), .timeAxis(timeAxis));
    // one apb transfer; data and error are taken at the completing edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // hang guard, well above the five 200 us sweeps
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 70000) begin
            errCount++;
            conclude();
        end
    end
    initial begin
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        `WAIT(measuring, 4)
        `CHK(measuring, 1'b1)
        `WAIT(sweepDone, 10200)
        `CHK(measuring & sweepDone, 1'b1)
        `CHK(timeAxis, 32'h0)
        bus(1'b1, 8'h00, 32'h3);
        bus(1'b1, 8'h08, 32'h0);
        bus(1'b1, 8'h0c, 32'hc8);
        `WAIT(sweepDone, 30000)
        repeat (4) @(posedge mclk);
        `CHK(measuring, 1'b0)
        chk(8'h24, 32'h1);
        chk(8'h34, 32'h0);
        `CHK(se, 1'b1)
        bus(1'b1, 8'h14, 32'hc8);
        chk(8'h14, 32'hc8);
        chk(8'h0c, 32'hc8);
        `CHK(zeroSpan, 1'b1)
        bus(1'b1, 8'h0c, 32'h64);
        chk(8'h2c, 32'hc8);
        bus(1'b1, 8'h0c, 32'h77359400);
        chk(8'h2c, 32'h3b9aca00);
        bus(1'b1, 8'h00, 32'h1);
        bus(1'b1, 8'h08, 32'h259);
        chk(8'h2c, 32'h9c40);
        bus(1'b1, 8'h10, 32'h4d2);
        chk(8'h10, 32'h4b0);
        bus(1'b1, 8'h10, 32'h5);
        chk(8'h10, 32'h0);
        // gating permission by source and sweep type, gate edit span
        bus(1'b1, 8'h00, 32'h21);
        bus(1'b0, 8'h28, 32'h0);
        `CHK(rd[3], 1'b0)
        bus(1'b1, 8'h00, 32'h29);
        bus(1'b0, 8'h28, 32'h0);
        `CHK(rd[3], 1'b1)
        bus(1'b1, 8'h00, 32'h69);
        bus(1'b0, 8'h28, 32'h0);
        `CHK(rd[3], 1'b0)
        bus(1'b1, 8'h00, 32'h81);
        `CHK(zeroSpan, 1'b1)
        bus(1'b1, 8'h00, 32'h1);
        `CHK(zeroSpan, 1'b0)
        chk(8'h08, 32'h259);
        // single, manual 200 us, video trigger at clamped full scale
        bus(1'b1, 8'h08, 32'h0);
        bus(1'b1, 8'h0c, 32'hc8);
        bus(1'b1, 8'h18, 32'h100);
        videoLevel <= 16'h0100;
        bus(1'b1, 8'h00, 32'h7);
        bus(1'b1, 8'h04, 32'h1);
        repeat (8) @(posedge mclk);
        `CHK(trigEvent | measuring, 1'b0)
        videoLevel <= 16'h0101;
        `WAIT(trigEvent, 4)
        `CHK(trigEvent, 1'b1)
        `WAIT(sweepDone, 10100)
        `CHK(sweepDone, 1'b1)
        // single, manual 200 us, external rising edge
        bus(1'b1, 8'h00, 32'hb);
        bus(1'b1, 8'h04, 32'h1);
        repeat (8) @(posedge mclk);
        `CHK(trigEvent | measuring, 1'b0)
        pinLvl <= 1'b1;
        `WAIT(trigEvent, 8)
        `CHK(trigEvent, 1'b1)
        `WAIT(measuring, 4)
        `CHK(measuring, 1'b1)
        `CHK(timeAxis, 32'h0)
        `WAIT(sweepDone, 10100)
        `CHK(sweepDone, 1'b1)
        // falling edge polarity
        bus(1'b1, 8'h00, 32'h1b);
        bus(1'b1, 8'h04, 32'h1);
        pinLvl <= 1'b0;
        `WAIT(trigEvent, 12)
        `CHK(trigEvent, 1'b1)
        `WAIT(sweepDone, 10100)
        // gated: 2 us measured, pause, resume on the next rising edge
        bus(1'b1, 8'h20, 32'h2);
        bus(1'b1, 8'h00, 32'h2b);
        bus(1'b1, 8'h04, 32'h1);
        pinLvl <= 1'b1;
        `WAIT(trigEvent, 8)
        `CHK(trigEvent, 1'b1)
        repeat (150) @(posedge mclk);
        `CHK(measuring, 1'b0)
        `CHK(timeAxis, 32'h2)
        pinLvl <= 1'b0;
        repeat (4) @(posedge mclk);
        pinLvl <= 1'b1;
        `WAIT(trigEvent, 8)
        `CHK(trigEvent, 1'b1)
        `WAIT(measuring, 4)
        `CHK(measuring, 1'b1)
        conclude();
    end
endmodule
`default_nettype wire
